// ==== verilog/fdc_status_pkg.sv ====
// constants for the floppy result status and reset block
package fdc_status_pkg;
    // first result status byte bit positions
    localparam int ST1_END_CYL   = 7;
    localparam int ST1_CRC       = 5;
    localparam int ST1_OVERRUN   = 4;
    localparam int ST1_NO_SECTOR = 2;
    localparam int ST1_WR_BLOCK  = 1;
    localparam int ST1_ADDR_SYNC = 0;
    // second result status byte bit positions
    localparam int ST2_CTRL_MARK = 6;
    localparam int ST2_PAY_CRC   = 5;
    localparam int ST2_TRK_MISS  = 4;
    localparam int ST2_BAD_TRK   = 1;
    localparam int ST2_PAY_SYNC  = 0;
    // drive status byte bit positions
    localparam int ST3_WP        = 6;
    localparam int ST3_ONE_HI    = 5;
    localparam int ST3_TRACK_ZERO_SENSE_PIN      = 4;
    localparam int ST3_ONE_LO    = 3;
    localparam int ST3_HEAD      = 2;
    localparam int ST3_DS1       = 1;
    localparam int ST3_DS0       = 0;
    // last sector number and hard-error track number
    localparam logic [7:0] LAST_SECTOR = 8'hFF;
    localparam logic [7:0] BAD_TRACK   = 8'hFF;
    // index pulses searched before giving up on an id mark
    localparam logic [1:0] INDEX_LIMIT = 2'h2;
    // values after reset
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic       POLL_RST    = 1'b1;
    // result byte selector
    localparam logic [1:0] SEL_ST1 = 2'h1;
    localparam logic [1:0] SEL_ST2 = 2'h2;
    localparam logic [1:0] SEL_ST3 = 2'h3;
    // command kinds seen by the status logic
    typedef enum logic [2:0] {
        CMD_OTHER, CMD_READ_DATA, CMD_READ_DEL, CMD_READ_ID,
        CMD_READ_TRACK, CMD_WRITE_DATA, CMD_WRITE_DEL, CMD_FORMAT
    } cmd_kind_e;
endpackage : fdc_status_pkg

// ==== verilog/pin_sync.sv ====
// two flip-flop synchroniser for a group of drive cable inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb
    begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_out = sync_r;
endmodule : pin_sync

// ==== verilog/fdc_result_status.sv ====
// result status bytes and reset handling of the floppy controller core
//
// Notes on behaviour
// R01: past last sector or no count: end flag
// R02: unused status bits read fixed values
// R03: any field crc error sets crc flag
// R04: missed service sets overrun flag
// R05: sector not found sets no-match flag
// R06: write protect during write sets blocked
// R07: id mark missing after two indexes
// R08: wrong data mark kind sets control flag
// R09: data field crc sets payload crc flag
// R10: id track differs sets mismatch flag
// R11: mismatch with track FF sets bad
// R12: no data mark sets payload sync flag
// R13: drive status shows live pin levels
// R14: drive status shows both select outputs
// R15: three reset sources reach the core
// R16: power-on reset initialises the core
// R17: any reset leaves power down
// R18: any reset aborts to idle
// R19: host avoids reset during writes
// R20: reset clears configure settings, awaits command
// R21: polling starts after reset unless disabled
// R22: status bytes read through data port
// R23: rate reset self-clears, control reset held
// R24: hardware reset sets held control bit
// R25: flags captured, held, cleared at command
`timescale 1ns/10ps
module fdc_result_status (
    input  wire logic       clk,
    input  wire logic       rst_b,
    // reset sources
    input  wire logic       host_reset_control_bit,
    input  wire logic       ctrl_reset_wr,
    input  wire logic       ctrl_reset_wdata,
    input  wire logic       rate_reset_wr,
    // command sequencing from the core
    input  wire logic       cmd_start,
    input  wire logic [2:0] cmd_kind,
    input  wire logic       cmd_done,
    input  wire logic       configure_wr,
    input  wire logic       configure_poll_off,
    input  wire logic       power_down_req,
    // events from the data separator and transfer logic
    input  wire logic [7:0] sector_number,
    input  wire logic       sector_access,
    input  wire logic       terminal_count_input,
    input  wire logic       id_crc_bad,
    input  wire logic       data_crc_bad,
    input  wire logic       service_missed,
    input  wire logic       sector_not_found,
    input  wire logic       id_read_bad,
    input  wire logic       track_seq_bad,
    input  wire logic       id_mark_seen,
    input  wire logic       data_mark_missing,
    input  wire logic       deleted_mark_seen,
    input  wire logic       normal_mark_seen,
    input  wire logic       id_valid,
    input  wire logic [7:0] id_track,
    input  wire logic [7:0] present_track,
    // drive cable
    input  wire logic       write_protect_pin,
    input  wire logic       track_zero_sense_pin,
    input  wire logic       index_pulse_pin,
    input  wire logic       head_side_pin,
    input  wire logic       drive_select_pin_one,
    input  wire logic       drive_select_pin_zero,
    // data port reads during the result phase
    input  wire logic       result_rd,
    input  wire logic [1:0] result_sel,
    output logic      [7:0] result_data,
    output logic            core_reset,
    output logic            power_down,
    output logic            poll_enable,
    output logic            ctrl_reset_bit
);
    logic [1:0] rst_sync_r;
    logic       rst_q_b;
    logic [5:0] pins_s;
    logic       wp_s;
    logic       track_zero_sense_pin_s;
    logic       idx_s;
    logic       head_s;
    logic       ds1_s;
    logic       ds0_s;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_q_b = rst_sync_r[1];

    pin_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .clk     (clk),
        .rst_b   (rst_q_b),
        .pin_in  ({write_protect_pin, track_zero_sense_pin, index_pulse_pin,
                   head_side_pin, drive_select_pin_one, drive_select_pin_zero}),
        .pin_out (pins_s)
    );
    assign {wp_s, track_zero_sense_pin_s, idx_s, head_s, ds1_s, ds0_s} = pins_s;

    // reset sources
    logic ctrl_reset_r;
    logic ctrl_reset_nxt;
    logic rate_reset_r;
    logic rate_reset_nxt;
    logic poll_r;
    logic poll_nxt;
    logic pdown_r;
    logic pdown_nxt;
    logic any_reset;

    assign any_reset = ctrl_reset_r | rate_reset_r | host_reset_control_bit; // R15

    always_comb
    begin
        ctrl_reset_nxt = ctrl_reset_r;
        // the host pin reset re-arms the held bit, over any host write
        if (host_reset_control_bit)
            ctrl_reset_nxt = 1'b1; // R24
        else if (ctrl_reset_wr)
            ctrl_reset_nxt = ctrl_reset_wdata; // R23
        // rate reset lasts one cycle then releases itself
        rate_reset_nxt = rate_reset_wr; // R23
        poll_nxt = poll_r;
        if (any_reset)
            poll_nxt = fdc_status_pkg::POLL_RST; // R20 R21
        else if (configure_wr)
            poll_nxt = ~configure_poll_off; // R21
        pdown_nxt = pdown_r;
        if (any_reset)
            pdown_nxt = 1'b0; // R17
        else if (power_down_req)
            pdown_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            ctrl_reset_r <= 1'b1; // R24 R16
            rate_reset_r <= 1'b0;
            poll_r       <= fdc_status_pkg::POLL_RST;
            pdown_r      <= 1'b0;
        end
        else
        begin
            ctrl_reset_r <= ctrl_reset_nxt;
            rate_reset_r <= rate_reset_nxt;
            poll_r       <= poll_nxt;
            pdown_r      <= pdown_nxt;
        end
    end

    // command phase tracking
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESULT} phase_e;
    phase_e     phase_r;
    phase_e     phase_nxt;
    logic [2:0] kind_r;
    logic [2:0] kind_nxt;
    logic [1:0] idx_cnt_r;
    logic [1:0] idx_cnt_nxt;
    logic       idx_d_r;
    logic       tc_seen_r;
    logic       tc_seen_nxt;
    logic [7:0] st1_r;
    logic [7:0] st1_nxt;
    logic [7:0] st2_r;
    logic [7:0] st2_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;

    function automatic logic is_kind(input logic [2:0] k, input fdc_status_pkg::cmd_kind_e c);
        is_kind = (k == 3'(c));
    endfunction : is_kind

    logic is_rd;
    logic is_rdel;
    logic is_wr;
    logic idx_rise;
    assign is_rd    = is_kind(kind_r, fdc_status_pkg::CMD_READ_DATA);
    assign is_rdel  = is_kind(kind_r, fdc_status_pkg::CMD_READ_DEL);
    assign is_wr    = is_kind(kind_r, fdc_status_pkg::CMD_WRITE_DATA)
                    | is_kind(kind_r, fdc_status_pkg::CMD_WRITE_DEL)
                    | is_kind(kind_r, fdc_status_pkg::CMD_FORMAT);
    assign idx_rise = idx_s & ~idx_d_r;

    always_comb
    begin
        phase_nxt   = phase_r;
        kind_nxt    = kind_r;
        idx_cnt_nxt = idx_cnt_r;
        tc_seen_nxt = tc_seen_r;
        st1_nxt     = st1_r;
        st2_nxt     = st2_r;
        data_nxt    = data_r;
        if (any_reset)
        begin
            // abort to idle and wipe captured state
            phase_nxt   = ST_IDLE; // R18 R20
            st1_nxt     = fdc_status_pkg::STATUS_RST;
            st2_nxt     = fdc_status_pkg::STATUS_RST;
            idx_cnt_nxt = 2'h0;
            tc_seen_nxt = 1'b0;
        end
        else
        begin
            unique case (phase_r)
                ST_IDLE, ST_RESULT:
                begin
                    if (cmd_start)
                    begin
                        phase_nxt   = ST_EXEC;
                        kind_nxt    = cmd_kind;
                        st1_nxt     = fdc_status_pkg::STATUS_RST; // R25
                        st2_nxt     = fdc_status_pkg::STATUS_RST; // R25
                        idx_cnt_nxt = 2'h0;
                        tc_seen_nxt = 1'b0;
                    end
                end
                ST_EXEC:
                begin
                    if (terminal_count_input)
                        tc_seen_nxt = 1'b1;
                    if (id_mark_seen)
                        idx_cnt_nxt = 2'h0;
                    else if (idx_rise && idx_cnt_r != fdc_status_pkg::INDEX_LIMIT)
                        idx_cnt_nxt = idx_cnt_r + 2'h1;
                    if (sector_access && sector_number == fdc_status_pkg::LAST_SECTOR)
                        st1_nxt[fdc_status_pkg::ST1_END_CYL] = 1'b1; // R01
                    if (id_crc_bad || data_crc_bad)
                        st1_nxt[fdc_status_pkg::ST1_CRC] = 1'b1; // R03
                    if (service_missed)
                        st1_nxt[fdc_status_pkg::ST1_OVERRUN] = 1'b1; // R04
                    if ((sector_not_found && (is_rd || is_rdel))
                        || (id_read_bad && is_kind(kind_r, fdc_status_pkg::CMD_READ_ID))
                        || (track_seq_bad && is_kind(kind_r, fdc_status_pkg::CMD_READ_TRACK)))
                        st1_nxt[fdc_status_pkg::ST1_NO_SECTOR] = 1'b1; // R05
                    if (wp_s && is_wr)
                        st1_nxt[fdc_status_pkg::ST1_WR_BLOCK] = 1'b1; // R06
                    if ((idx_cnt_r == fdc_status_pkg::INDEX_LIMIT) || data_mark_missing)
                        st1_nxt[fdc_status_pkg::ST1_ADDR_SYNC] = 1'b1; // R07
                    if ((is_rd && deleted_mark_seen) || (is_rdel && normal_mark_seen))
                        st2_nxt[fdc_status_pkg::ST2_CTRL_MARK] = 1'b1; // R08
                    if (data_crc_bad)
                        st2_nxt[fdc_status_pkg::ST2_PAY_CRC] = 1'b1; // R09
                    if (id_valid && id_track != present_track)
                    begin
                        st2_nxt[fdc_status_pkg::ST2_TRK_MISS] = 1'b1; // R10
                        if (id_track == fdc_status_pkg::BAD_TRACK)
                            st2_nxt[fdc_status_pkg::ST2_BAD_TRK] = 1'b1; // R11
                    end
                    if (data_mark_missing)
                        st2_nxt[fdc_status_pkg::ST2_PAY_SYNC] = 1'b1; // R12
                    if (cmd_done)
                    begin
                        phase_nxt = ST_RESULT;
                        if (!tc_seen_r && !terminal_count_input
                            && (is_rd || is_kind(kind_r, fdc_status_pkg::CMD_WRITE_DATA)))
                            st1_nxt[fdc_status_pkg::ST1_END_CYL] = 1'b1; // R01
                    end
                end
            endcase
        end
        // result bytes reach the data port register
        if (result_rd)
        begin
            unique case (result_sel)
                fdc_status_pkg::SEL_ST1: data_nxt = st1_r; // R22
                fdc_status_pkg::SEL_ST2: data_nxt = st2_r; // R22
                fdc_status_pkg::SEL_ST3:
                begin
                    data_nxt = 8'h00; // R02
                    data_nxt[fdc_status_pkg::ST3_ONE_HI] = 1'b1; // R02
                    data_nxt[fdc_status_pkg::ST3_ONE_LO] = 1'b1; // R02
                    data_nxt[fdc_status_pkg::ST3_WP]     = wp_s; // R13
                    data_nxt[fdc_status_pkg::ST3_TRACK_ZERO_SENSE_PIN]   = track_zero_sense_pin_s; // R13
                    data_nxt[fdc_status_pkg::ST3_HEAD]   = head_s; // R13
                    data_nxt[fdc_status_pkg::ST3_DS1]    = ds1_s; // R14
                    data_nxt[fdc_status_pkg::ST3_DS0]    = ds0_s; // R14
                end
                default: data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            phase_r   <= ST_IDLE;
            kind_r    <= 3'h0;
            idx_cnt_r <= 2'h0;
            idx_d_r   <= 1'b0;
            tc_seen_r <= 1'b0;
            st1_r     <= fdc_status_pkg::STATUS_RST;
            st2_r     <= fdc_status_pkg::STATUS_RST;
            data_r    <= 8'h00;
        end
        else
        begin
            phase_r   <= phase_nxt;
            kind_r    <= kind_nxt;
            idx_cnt_r <= idx_cnt_nxt;
            idx_d_r   <= idx_s;
            tc_seen_r <= tc_seen_nxt;
            st1_r     <= st1_nxt;
            st2_r     <= st2_nxt;
            data_r    <= data_nxt;
        end
    end

    // core reset is registered so the output stays glitch free
    logic core_reset_r;
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
            core_reset_r <= 1'b1;
        else
            core_reset_r <= any_reset; // R18
    end

    assign result_data    = data_r;
    assign core_reset     = core_reset_r;
    assign power_down     = pdown_r;
    assign poll_enable    = poll_r;
    assign ctrl_reset_bit = ctrl_reset_r;
endmodule : fdc_result_status

// ==== verif/drive_cable_model.sv ====
// drive cable model: sense lines and index pulses
`timescale 1ns/10ps
module drive_cable_model (
    input  wire logic       clk,
    input  wire logic       wp_lvl,
    input  wire logic       track_zero_sense_pin_lvl,
    input  wire logic       head_lvl,
    input  wire logic [1:0] ds_lvl,
    input  wire logic       idx_req,
    output logic            write_protect_pin,
    output logic            track_zero_sense_pin,
    output logic            index_pulse_pin,
    output logic            head_side_pin,
    output logic            drive_select_pin_one,
    output logic            drive_select_pin_zero
);
    logic [2:0] idx_cnt_r = 3'h0;
    // pulse spans several clocks so the pin synchroniser cannot miss it
    always_ff @(posedge clk)
    begin
        if (idx_req)
            idx_cnt_r <= 3'h4;
        else if (idx_cnt_r != 3'h0)
            idx_cnt_r <= idx_cnt_r - 3'h1;
    end
    assign index_pulse_pin       = idx_cnt_r != 3'h0;
    assign write_protect_pin     = wp_lvl;
    assign track_zero_sense_pin  = track_zero_sense_pin_lvl;
    assign head_side_pin         = head_lvl;
    assign drive_select_pin_one  = ds_lvl[1];
    assign drive_select_pin_zero = ds_lvl[0];
endmodule : drive_cable_model

// ==== verif/fdc_result_status_assertions.sv ====
// port assertions for the result status block
`timescale 1ns/10ps
module fdc_result_status_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       host_reset_control_bit,
    input wire logic       rate_reset_wr,
    input wire logic       result_rd,
    input wire logic [1:0] result_sel,
    input wire logic [7:0] result_data,
    input wire logic       core_reset,
    input wire logic       power_down,
    input wire logic       poll_enable,
    input wire logic       ctrl_reset_bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(logic [1:0] s);
        result_rd && result_sel == s;
    endsequence
    sequence s_quiet;
        !rate_reset_wr && !host_reset_control_bit && !ctrl_reset_bit;
    endsequence
    a_sel_zero: assert property (s_rd(2'h0) |=> result_data == 8'h00)
        else $error("idle selector gave data");
    a_st1_fixed: assert property (
        s_rd(2'h1) |=> (result_data & 8'h48) == 8'h00)
        else $error("unused bits of first byte set");
    a_st2_fixed: assert property (
        s_rd(2'h2) |=> (result_data & 8'h8C) == 8'h00)
        else $error("unused bits of second byte set");
    a_st3_fixed: assert property (
        s_rd(2'h3) |=> (result_data & 8'hA8) == 8'h28)
        else $error("fixed bits of drive byte wrong");
    a_ctrl_core: assert property (ctrl_reset_bit |=> core_reset)
        else $error("held reset bit did not reset core");
    a_host_core: assert property (host_reset_control_bit |=> core_reset)
        else $error("host reset did not reset core");
    a_rate_on: assert property (rate_reset_wr |-> ##[1:2] core_reset)
        else $error("rate reset did not reset core");
    a_rate_self: assert property (
        rate_reset_wr ##1 s_quiet [*4] |-> !core_reset)
        else $error("rate reset did not clear itself");
    a_down_exit: assert property (core_reset |-> ##[0:1] !power_down)
        else $error("reset left power down set");
    a_poll_on: assert property (core_reset |-> ##[0:1] poll_enable)
        else $error("reset left polling off");
    a_data_hold: assert property (
        !result_rd && !core_reset ##1 !core_reset |-> $stable(result_data))
        else $error("result byte changed without a read");
endmodule : fdc_result_status_checker
bind fdc_result_status fdc_result_status_checker u_chk (.clk, .rst_b,
    .host_reset_control_bit, .rate_reset_wr, .result_rd, .result_sel,
    .result_data, .core_reset, .power_down, .poll_enable, .ctrl_reset_bit);

// ==== verif/tb_top.sv ====
// self-checking bench for the result status block
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst_b, host_reset_control_bit, ctrl_reset_wr, ctrl_reset_wdata;
    logic        rate_reset_wr, cmd_start, cmd_done, configure_wr, configure_poll_off;
    logic        power_down_req, terminal_count_input, result_rd, idx_req, sector_access;
    logic        wp_lvl, track_zero_sense_pin_lvl, head_lvl;
    logic [1:0]  ds_lvl, result_sel;
    logic [2:0]  cmd_kind;
    logic [7:0]  id_track, present_track, result_data, sector_number;
    logic [10:0] ev_r;
    logic        core_reset, power_down, poll_enable, ctrl_reset_bit;
    logic        wp_p, track_zero_sense_pin_p, idx_p, head_p, ds1_p, ds0_p;
    int          err_total, checks_done;
    wire  [7:0]  ctl_v = {4'h0, ctrl_reset_bit, core_reset, poll_enable, power_down};
    fdc_result_status u_fdc_result_status (.clk(clk), .rst_b(rst_b),
        .host_reset_control_bit(host_reset_control_bit), .ctrl_reset_wr(ctrl_reset_wr),
        .ctrl_reset_wdata(ctrl_reset_wdata), .rate_reset_wr(rate_reset_wr),
        .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_done(cmd_done),
        .configure_wr(configure_wr), .configure_poll_off(configure_poll_off),
        .power_down_req(power_down_req), .sector_number(sector_number),
        .sector_access(sector_access),
        .terminal_count_input(terminal_count_input), .id_crc_bad(ev_r[0]),
        .data_crc_bad(ev_r[1]), .service_missed(ev_r[2]), .sector_not_found(ev_r[3]),
        .id_read_bad(ev_r[4]), .track_seq_bad(ev_r[5]), .id_mark_seen(ev_r[6]),
        .data_mark_missing(ev_r[7]), .deleted_mark_seen(ev_r[8]),
        .normal_mark_seen(ev_r[9]), .id_valid(ev_r[10]), .id_track(id_track),
        .present_track(present_track), .write_protect_pin(wp_p),
        .track_zero_sense_pin(track_zero_sense_pin_p), .index_pulse_pin(idx_p), .head_side_pin(head_p),
        .drive_select_pin_one(ds1_p), .drive_select_pin_zero(ds0_p),
        .result_rd(result_rd), .result_sel(result_sel), .result_data(result_data),
        .core_reset(core_reset), .power_down(power_down), .poll_enable(poll_enable),
        .ctrl_reset_bit(ctrl_reset_bit));
    drive_cable_model u_drive_cable_model (.clk(clk), .wp_lvl(wp_lvl), .track_zero_sense_pin_lvl(track_zero_sense_pin_lvl),
        .head_lvl(head_lvl), .ds_lvl(ds_lvl), .idx_req(idx_req), .write_protect_pin(wp_p),
        .track_zero_sense_pin(track_zero_sense_pin_p), .index_pulse_pin(idx_p), .head_side_pin(head_p),
        .drive_select_pin_one(ds1_p), .drive_select_pin_zero(ds0_p));
    // rows: kind, events, count seen, first byte, second byte
    logic [35:0] tab [12] = '{36'h1_001_1_20_00, 36'h1_002_1_20_20, 36'h1_004_1_10_00,
        36'h1_008_1_04_00, 36'h3_010_1_04_00, 36'h4_020_1_04_00, 36'h1_080_1_01_01,
        36'h1_100_1_00_40, 36'h2_200_1_00_40, 36'h2_100_1_00_00, 36'h1_000_0_80_00,
        36'h5_000_0_80_00};
    logic [23:0] trk [4] = '{24'h05_03_10, 24'hFF_03_12, 24'hFF_FF_00, 24'h07_07_00};
    logic [4:0]  dpat [4] = '{5'h15, 5'h0A, 5'h1F, 5'h00};
    logic [2:0]  wk [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic rd(logic [1:0] s, output logic [7:0] v);
        @(posedge clk);
        result_rd  <= 1'h1;
        result_sel <= s;
        @(posedge clk);
        result_rd <= 1'h0;
        #1 v = result_data;
    endtask : rd
    task automatic go(logic [2:0] k, logic tc);
        @(posedge clk);
        cmd_start            <= 1'h1;
        cmd_kind             <= k;
        terminal_count_input <= tc;
        @(posedge clk);
        cmd_start <= 1'h0;
    endtask : go
    task automatic pev(logic [10:0] m);
        @(posedge clk);
        ev_r <= m;
        @(posedge clk);
        ev_r <= 11'h000;
    endtask : pev
    task automatic fin(string nm, logic [7:0] e1, logic [7:0] e2);
        logic [7:0] v;
        @(posedge clk);
        cmd_done <= 1'h1;
        @(posedge clk);
        cmd_done <= 1'h0;
        rd(2'h1, v);
        chk({nm, " first"}, e1, v);
        rd(2'h2, v);
        chk({nm, " second"}, e2, v);
    endtask : fin
    task automatic ctrl_wr(logic d);
        @(posedge clk);
        ctrl_reset_wr    <= 1'h1;
        ctrl_reset_wdata <= d;
        @(posedge clk);
        ctrl_reset_wr <= 1'h0;
        tick(3);
        #1;
    endtask : ctrl_wr
    task automatic rate;
        @(posedge clk);
        rate_reset_wr <= 1'h1;
        @(posedge clk);
        rate_reset_wr <= 1'h0;
        tick(4);
        #1;
    endtask : rate
    task automatic idx;
        @(posedge clk);
        idx_req <= 1'h1;
        @(posedge clk);
        idx_req <= 1'h0;
        tick(6);
    endtask : idx
    task automatic t_flags;
        foreach (tab[i])
        begin
            go(tab[i][34:32], tab[i][16]);
            pev(tab[i][30:20]);
            fin("flags", tab[i][15:8], tab[i][7:0]);
        end
        go(3'h1, 1'h1);
        {sector_access, sector_number} <= 9'h1FF;
        @(posedge clk);
        sector_access <= 1'h0;
        fin("last sector", 8'h80, 8'h00);
    endtask : t_flags
    task automatic t_wp;
        foreach (wk[i])
        begin
            go(wk[i], 1'h1);
            wp_lvl <= 1'h1;
            tick(4);
            fin("protect", (wk[i] > 3'h1) ? 8'h02 : 8'h00, 8'h00);
            @(posedge clk);
            wp_lvl <= 1'h0;
            tick(4);
        end
    endtask : t_wp
    task automatic t_index;
        go(3'h1, 1'h1);
        idx();
        idx();
        fin("two index", 8'h01, 8'h00);
        go(3'h1, 1'h1);
        idx();
        pev(11'h040);
        idx();
        fin("mark found", 8'h00, 8'h00);
    endtask : t_index
    task automatic t_track;
        foreach (trk[i])
        begin
            go(3'h1, 1'h1);
            id_track      <= trk[i][23:16];
            present_track <= trk[i][15:8];
            pev(11'h400);
            fin("track", 8'h00, trk[i][7:0]);
        end
    endtask : t_track
    task automatic t_drive;
        logic [7:0] v;
        foreach (dpat[i])
        begin
            @(posedge clk);
            {wp_lvl, track_zero_sense_pin_lvl, head_lvl, ds_lvl} <= dpat[i];
            tick(4);
            rd(2'h3, v);
            chk("drive", {3'h1, dpat[i][3], 1'h1, dpat[i][2:0]} | {1'h0, dpat[i][4], 6'h00}, v);
        end
        rd(2'h0, v);
        chk("idle select", 8'h00, v);
    endtask : t_drive
    task automatic t_soft;
        @(posedge clk);
        configure_wr       <= 1'h1;
        configure_poll_off <= 1'h1;
        @(posedge clk);
        configure_wr <= 1'h0;
        tick(2);
        #1 chk("poll off", 8'h00, ctl_v);
        rate();
        chk("rate reset", 8'h02, ctl_v);
        ctrl_wr(1'h1);
        chk("held reset", 8'h0E, ctl_v);
        rate();
        chk("held over rate", 8'h0E, ctl_v);
        ctrl_wr(1'h0);
        chk("released", 8'h02, ctl_v);
    endtask : t_soft
    task automatic t_abort;
        logic [7:0] v;
        @(posedge clk);
        power_down_req <= 1'h1;
        @(posedge clk);
        power_down_req <= 1'h0;
        tick(2);
        #1 chk("power down", 8'h03, ctl_v);
        go(3'h1, 1'h1);
        pev(11'h002);
        @(posedge clk);
        host_reset_control_bit <= 1'h1;
        tick(3);
        #1 chk("host reset", 8'h0E, ctl_v);
        @(posedge clk);
        host_reset_control_bit <= 1'h0;
        ctrl_wr(1'h0);
        rd(2'h1, v);
        chk("aborted", 8'h00, v);
    endtask : t_abort
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        {rst_b, host_reset_control_bit, ctrl_reset_wr, ctrl_reset_wdata, rate_reset_wr} = 5'h00;
        {cmd_start, cmd_done, configure_wr, configure_poll_off, power_down_req} = 5'h00;
        {terminal_count_input, result_rd, idx_req, wp_lvl, track_zero_sense_pin_lvl, head_lvl} = 6'h00;
        {ds_lvl, result_sel, cmd_kind, ev_r} = 18'h00000;
        {id_track, present_track} = 16'h0000;
        {sector_access, sector_number} = 9'h000;
        tick(6);
        rst_b <= 1'h1;
        tick(3);
        #1 chk("after reset", 8'h0E, ctl_v);
        ctrl_wr(1'h0);
        chk("ready", 8'h02, ctl_v);
        t_flags();
        t_wp();
        t_index();
        t_track();
        t_drive();
        t_soft();
        t_abort();
        give_verdict();
    end
endmodule : tb_top
